// ==== pkg/seq_pkg.sv ====
// constants and types for the radio mode sequencer.
// assumes a single 20 MHz clock and an AHB-Lite register port.
package seq_pkg;

	localparam int CLK_NS = 50;

	// timer tick lengths as printed, in ns, and their cycle counts
	localparam int RES1_NS  = 64000;
	localparam int RES2_NS  = 4100000;
	localparam int RES3_NS  = 262000000;
	localparam int RES1_CYC = RES1_NS / CLK_NS;
	localparam int RES2_CYC = RES2_NS / CLK_NS;
	localparam int RES3_CYC = RES3_NS / CLK_NS;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] CFG_OFS    = 8'h04;
	localparam logic [7:0] TIMER_OFS  = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;

	// control word bits
	localparam int LAUNCH_BIT = 0;
	localparam int HALT_BIT   = 1;

	// sequencer_control_word field positions
	localparam int IDLE_LP_BIT   = 0;
	localparam int LAUNCH_LSB    = 1;
	localparam int LP_STEP_BIT   = 3;
	localparam int IDLE_EXIT_BIT = 4;
	localparam int TX_EXIT_BIT   = 5;
	localparam int RX_EXIT_LSB   = 6;
	localparam int TO_EXIT_LSB   = 9;
	localparam int GOT_EXIT_LSB  = 11;
	localparam int FLUSH_BIT     = 14;
	localparam int CFG_W         = 15;
	localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;

	// timer word field positions
	localparam int T1_SEL_LSB  = 0;
	localparam int T2_SEL_LSB  = 2;
	localparam int T1_MULT_LSB = 8;
	localparam int T2_MULT_LSB = 16;
	localparam int TMR_W       = 24;
	localparam logic [TMR_W-1:0] TMR_RST = 24'h000000;

	// status word field positions
	localparam int ST_STATE_LSB = 0;
	localparam int ST_MODE_LSB  = 4;
	localparam int ST_PHASE_LSB = 8;
	localparam int ST_INIT_LSB  = 12;

	// chip modes requested from the radio
	localparam logic [2:0] MODE_SLEEP   = 3'h0;
	localparam logic [2:0] MODE_STANDBY = 3'h1;
	localparam logic [2:0] MODE_SYNTH   = 3'h2;
	localparam logic [2:0] MODE_TX      = 3'h3;
	localparam logic [2:0] MODE_RX      = 3'h4;

	typedef enum logic [2:0] {
		seq_halted_state,
		lowpower_idle_state,
		fifo_wait_state,
		tx_state,
		rx_state,
		got_packet_state,
		rx_relaunch_state,
		synth_wait_state
	} seq_state_t;

	typedef enum logic [1:0] {
		timer_stopped,
		timer_first,
		timer_second
	} timer_phase_t;

endpackage : seq_pkg

// ==== src/radio_mode_sequencer.sv ====
// radio mode sequencer: programmable state machine plus chained interval timers.
// assumes radio events are one-cycle pulses from logic on hclk; registers sit on AHB-Lite.
//
// Behaviour
// - idle low-power choice 0 holds standby, 1 holds sleep while idle.
// - launch from sleep/standby goes to low-power step, receive, transmit or fifo wait.
// - low-power step 0 halts with launch-time mode restored; 1 enters idle.
// - idle exits on timer1 to tx or rx; tx exits on sent to low-power or rx.
// - rx exit 001/010/011 on payload or check pass; bad check acts as timeout unless the flush bit is set.
// - rx exit 100/101/110 halt on strength/sync/preamble; timer2 forces low-power step.
// - receive timeout exit selects relaunch, transmit, low-power step or halt.
// - receive timeout is any of strength, preamble or sync deadline events.
// - got-packet exit selects halt, tx on drained, low-power, synth then rx, rx.
// - timer1 fires resolution times multiplier after timer2 or launch; code 00 disables.
// - timer2 fires resolution times multiplier after timer1, same encoding.
// - timer alternation runs regardless of sequencer state.
// - halt command forces the sequencer off from any state.
// - fifo wait stays put until the fifo level event, then transmits.
// - low-power idle responds only to timer1.
// - relaunch state restarts receiver gain and frequency tracking before rx.
// - idle entered from a low-power request places the chip in sleep or standby per the idle low-power choice.
`timescale 1ns/1ns

module radio_mode_sequencer #(
	parameter int unsigned RES2_CYC = seq_pkg::RES2_CYC,	// 4.1 ms tick length in cycles
	parameter int unsigned RES3_CYC = seq_pkg::RES3_CYC	// 262 ms tick length in cycles
) (
	input  wire logic        hclk,                    // bus and core clock
	input  wire logic        hresetn,                 // async reset, active low
	input  wire logic        hsel,                    // slave select
	input  wire logic [31:0] haddr,                   // byte address
	input  wire logic [1:0]  htrans,                  // transfer type
	input  wire logic        hwrite,                  // write not read
	input  wire logic [2:0]  hsize,                   // transfer size
	input  wire logic [31:0] hwdata,                  // write data
	input  wire logic        hready,                  // bus ready
	output logic      [31:0] hrdata,                  // read data
	output logic             hreadyout,               // slave ready
	output logic             hresp,                   // response, always okay
	input  wire logic [2:0]  chip_mode,               // current radio mode
	input  wire logic        tx_done_event,           // packet sent
	input  wire logic        rx_payload_event,        // payload ready
	input  wire logic        check_pass_event,        // crc ok
	input  wire logic        strength_event,          // signal strength above threshold
	input  wire logic        sync_match_event,        // sync or address match
	input  wire logic        preamble_found_event,    // preamble detected
	input  wire logic        fifo_level_event,        // fifo threshold
	input  wire logic        fifo_drained_event,      // fifo empty
	input  wire logic        strength_deadline_event, // strength timeout
	input  wire logic        preamble_deadline_event, // preamble timeout
	input  wire logic        sync_deadline_event,     // sync timeout
	input  wire logic        synth_locked,            // synthesiser settled
	output logic      [2:0]  mode_req,                // requested radio mode
	output logic             seq_active,              // sequencer not halted
	output logic             rx_restart,              // receiver restart pulse
	output logic             first_timer_event,       // timer1 pulse
	output logic             second_timer_event,      // timer2 pulse
	output logic             rx_deadline_event        // combined receive timeout
);

	////////////////////////////////////////////////////////////////////////////
	// register port

	logic                       wr_pend_r;
	logic                       rd_ok;
	logic [7:0]                 wr_addr_r;
	logic [seq_pkg::CFG_W-1:0]  cfg_r;
	logic [seq_pkg::TMR_W-1:0]  tmr_r;
	logic                       launch_r;
	logic                       halt_r;
	logic [31:0]                hrdata_r;
	logic [31:0]                status;
	logic                       ctrl_wr;

	seq_pkg::seq_state_t        state_r;
	seq_pkg::seq_state_t        state_nxt;
	seq_pkg::timer_phase_t      phase_r;
	logic [2:0]                 mode_r;
	logic [2:0]                 mode_nxt;
	logic [2:0]                 init_mode_r;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	assign rd_ok     = hsel & htrans[1] & hready & ~hwrite;
	assign ctrl_wr   = wr_pend_r & (wr_addr_r == seq_pkg::CTRL_OFS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= hsel & htrans[1] & hready & hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r <= seq_pkg::CFG_RST;
			tmr_r <= seq_pkg::TMR_RST;
		end else if (wr_pend_r) begin
			if (wr_addr_r == seq_pkg::CFG_OFS)
				cfg_r <= hwdata[seq_pkg::CFG_W-1:0];
			if (wr_addr_r == seq_pkg::TIMER_OFS)
				tmr_r <= hwdata[seq_pkg::TMR_W-1:0];
		end
	end

	// command bits never store; they live one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			launch_r <= 1'b0;
			halt_r   <= 1'b0;
		end else begin
			halt_r   <= ctrl_wr & hwdata[seq_pkg::HALT_BIT];
			launch_r <= ctrl_wr & hwdata[seq_pkg::LAUNCH_BIT] & ~hwdata[seq_pkg::HALT_BIT];
		end
	end

	always_comb begin
		status = 32'h00000000;
		status[seq_pkg::ST_STATE_LSB +: 3] = state_r;
		status[seq_pkg::ST_MODE_LSB  +: 3] = mode_r;
		status[seq_pkg::ST_PHASE_LSB +: 2] = phase_r;
		status[seq_pkg::ST_INIT_LSB  +: 3] = init_mode_r;
	end

	// read data captured at the address phase; a read right after a write
	// to the same word returns the old value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_r <= 32'h00000000;
		else if (rd_ok) begin
			unique case (haddr[7:0])
				seq_pkg::CFG_OFS:    hrdata_r <= {17'h00000, cfg_r};
				seq_pkg::TIMER_OFS:  hrdata_r <= {8'h00, tmr_r};
				seq_pkg::STATUS_OFS: hrdata_r <= status;
				default:             hrdata_r <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration fields

	logic       idle_lowpower_choice;
	logic [1:0] launch_exit_select;
	logic       lowpower_step_select;
	logic       idle_exit_select;
	logic       tx_exit_select;
	logic [2:0] rx_exit_select;
	logic [1:0] timeout_exit_select;
	logic [2:0] got_packet_exit_select;
	logic       bad_check_flush_enable;
	logic [1:0] first_timer_tick_select;
	logic [1:0] second_timer_tick_select;
	logic [7:0] first_timer_multiplier;
	logic [7:0] second_timer_multiplier;

	assign idle_lowpower_choice     = cfg_r[seq_pkg::IDLE_LP_BIT];
	assign launch_exit_select       = cfg_r[seq_pkg::LAUNCH_LSB +: 2];
	assign lowpower_step_select     = cfg_r[seq_pkg::LP_STEP_BIT];
	assign idle_exit_select         = cfg_r[seq_pkg::IDLE_EXIT_BIT];
	assign tx_exit_select           = cfg_r[seq_pkg::TX_EXIT_BIT];
	assign rx_exit_select           = cfg_r[seq_pkg::RX_EXIT_LSB +: 3];
	assign timeout_exit_select      = cfg_r[seq_pkg::TO_EXIT_LSB +: 2];
	assign got_packet_exit_select   = cfg_r[seq_pkg::GOT_EXIT_LSB +: 3];
	assign bad_check_flush_enable   = cfg_r[seq_pkg::FLUSH_BIT];
	assign first_timer_tick_select  = tmr_r[seq_pkg::T1_SEL_LSB +: 2];
	assign second_timer_tick_select = tmr_r[seq_pkg::T2_SEL_LSB +: 2];
	assign first_timer_multiplier   = tmr_r[seq_pkg::T1_MULT_LSB +: 8];
	assign second_timer_multiplier  = tmr_r[seq_pkg::T2_MULT_LSB +: 8];

	////////////////////////////////////////////////////////////////////////////
	// chained timers

	logic        launch_ok;
	logic        launch_go;
	logic [22:0] presc_r;
	logic [7:0]  tcount_r;
	logic [1:0]  cur_sel;
	logic [7:0]  cur_mult;
	logic        tick;
	logic        fire;

	function automatic logic [22:0] tick_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h1:    tick_cycles = 23'(seq_pkg::RES1_CYC);
			2'h2:    tick_cycles = 23'(RES2_CYC);
			2'h3:    tick_cycles = 23'(RES3_CYC);
			default: tick_cycles = 23'h7FFFFF;
		endcase
	endfunction : tick_cycles

	assign launch_ok = (chip_mode == seq_pkg::MODE_SLEEP) | (chip_mode == seq_pkg::MODE_STANDBY);
	assign launch_go = launch_r & launch_ok;
	assign cur_sel   = (phase_r == seq_pkg::timer_first) ? first_timer_tick_select : second_timer_tick_select;
	assign cur_mult  = (phase_r == seq_pkg::timer_first) ? first_timer_multiplier : second_timer_multiplier;
	assign tick      = (presc_r == tick_cycles(cur_sel) - 23'h000001);
	// a multiplier of zero behaves as one tick
	assign fire      = (phase_r != seq_pkg::timer_stopped) & tick
	                   & ({1'b0, tcount_r} + 9'h001 >= {1'b0, cur_mult});

	// runs whatever the sequencer state; only launch restarts it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_r            <= seq_pkg::timer_stopped;
			presc_r            <= 23'h000000;
			tcount_r           <= 8'h00;
			first_timer_event  <= 1'b0;
			second_timer_event <= 1'b0;
		end else begin
			first_timer_event  <= 1'b0;
			second_timer_event <= 1'b0;
			if (launch_go) begin
				presc_r  <= 23'h000000;
				tcount_r <= 8'h00;
				phase_r  <= (first_timer_tick_select != 2'h0) ? seq_pkg::timer_first
				                                              : seq_pkg::timer_stopped;
			end else if (phase_r != seq_pkg::timer_stopped && cur_sel == 2'h0) begin
				phase_r <= seq_pkg::timer_stopped;
			end else if (fire) begin
				presc_r  <= 23'h000000;
				tcount_r <= 8'h00;
				if (phase_r == seq_pkg::timer_first) begin
					first_timer_event <= 1'b1;
					phase_r <= (second_timer_tick_select != 2'h0) ? seq_pkg::timer_second
					                                              : seq_pkg::timer_stopped;
				end else begin
					second_timer_event <= 1'b1;
					phase_r <= (first_timer_tick_select != 2'h0) ? seq_pkg::timer_first
					                                             : seq_pkg::timer_stopped;
				end
			end else if (phase_r != seq_pkg::timer_stopped) begin
				if (tick) begin
					presc_r  <= 23'h000000;
					tcount_r <= tcount_r + 8'h01;
				end else begin
					presc_r <= presc_r + 23'h000001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer state machine

	logic                 bad_check;
	logic                 rx_timeout;
	seq_pkg::seq_state_t  lp_state;
	logic [2:0]           lp_mode;
	seq_pkg::seq_state_t  to_state;
	logic [2:0]           to_mode;

	assign rx_timeout = strength_deadline_event | preamble_deadline_event | sync_deadline_event;
	assign rx_deadline_event = rx_timeout;
	assign bad_check  = (rx_exit_select == 3'h3) & rx_payload_event & ~check_pass_event
	                    & ~bad_check_flush_enable;

	// low-power step target
	always_comb begin
		if (lowpower_step_select) begin
			lp_state = seq_pkg::lowpower_idle_state;
			lp_mode  = idle_lowpower_choice ? seq_pkg::MODE_SLEEP : seq_pkg::MODE_STANDBY;
		end else begin
			lp_state = seq_pkg::seq_halted_state;
			lp_mode  = init_mode_r;
		end
	end

	// receive timeout target
	always_comb begin
		unique case (timeout_exit_select)
			2'h0: begin
				to_state = seq_pkg::rx_relaunch_state;
				to_mode  = seq_pkg::MODE_RX;
			end
			2'h1: begin
				to_state = seq_pkg::tx_state;
				to_mode  = seq_pkg::MODE_TX;
			end
			2'h2: begin
				to_state = lp_state;
				to_mode  = lp_mode;
			end
			default: begin
				to_state = seq_pkg::seq_halted_state;
				to_mode  = mode_r;
			end
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		mode_nxt  = mode_r;
		if (halt_r) begin
			state_nxt = seq_pkg::seq_halted_state;
		end else if (launch_go) begin
			unique case (launch_exit_select)
				2'h0: begin
					state_nxt = lp_state;
					mode_nxt  = lowpower_step_select ? lp_mode : chip_mode;
				end
				2'h1: begin
					state_nxt = seq_pkg::rx_state;
					mode_nxt  = seq_pkg::MODE_RX;
				end
				2'h2: begin
					state_nxt = seq_pkg::tx_state;
					mode_nxt  = seq_pkg::MODE_TX;
				end
				default: begin
					state_nxt = seq_pkg::fifo_wait_state;
					mode_nxt  = chip_mode;
				end
			endcase
		end else begin
			unique case (state_r)
				seq_pkg::seq_halted_state: ;
				seq_pkg::lowpower_idle_state: begin
					if (first_timer_event) begin
						state_nxt = idle_exit_select ? seq_pkg::rx_state : seq_pkg::tx_state;
						mode_nxt  = idle_exit_select ? seq_pkg::MODE_RX : seq_pkg::MODE_TX;
					end
				end
				seq_pkg::fifo_wait_state: begin
					if (fifo_level_event) begin
						state_nxt = seq_pkg::tx_state;
						mode_nxt  = seq_pkg::MODE_TX;
					end
				end
				seq_pkg::tx_state: begin
					if (tx_done_event) begin
						state_nxt = tx_exit_select ? seq_pkg::rx_state : lp_state;
						mode_nxt  = tx_exit_select ? seq_pkg::MODE_RX : lp_mode;
					end
				end
				seq_pkg::rx_state: begin
					if (second_timer_event) begin
						state_nxt = lp_state;
						mode_nxt  = lp_mode;
					end else if (rx_timeout || bad_check) begin
						state_nxt = to_state;
						mode_nxt  = to_mode;
					end else begin
						unique case (rx_exit_select)
							3'h1: if (rx_payload_event) state_nxt = seq_pkg::got_packet_state;
							3'h2: if (rx_payload_event) begin
								state_nxt = lp_state;
								mode_nxt  = lp_mode;
							end
							3'h3: if (check_pass_event) state_nxt = seq_pkg::got_packet_state;
							3'h4: if (strength_event) state_nxt = seq_pkg::seq_halted_state;
							3'h5: if (sync_match_event) state_nxt = seq_pkg::seq_halted_state;
							3'h6: if (preamble_found_event) state_nxt = seq_pkg::seq_halted_state;
							default: ;
						endcase
					end
				end
				seq_pkg::got_packet_state: begin
					unique case (got_packet_exit_select)
						3'h0: state_nxt = seq_pkg::seq_halted_state;
						3'h1: if (fifo_drained_event) begin
							state_nxt = seq_pkg::tx_state;
							mode_nxt  = seq_pkg::MODE_TX;
						end
						3'h2: begin
							state_nxt = lp_state;
							mode_nxt  = lp_mode;
						end
						3'h3: begin
							state_nxt = seq_pkg::synth_wait_state;
							mode_nxt  = seq_pkg::MODE_SYNTH;
						end
						3'h4: state_nxt = seq_pkg::rx_state;
						default: ;
					endcase
				end
				seq_pkg::rx_relaunch_state: begin
					state_nxt = seq_pkg::rx_state;
					mode_nxt  = seq_pkg::MODE_RX;
				end
				seq_pkg::synth_wait_state: begin
					if (synth_locked) begin
						state_nxt = seq_pkg::rx_state;
						mode_nxt  = seq_pkg::MODE_RX;
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= seq_pkg::seq_halted_state;
			mode_r  <= seq_pkg::MODE_STANDBY;
		end else begin
			state_r <= state_nxt;
			mode_r  <= mode_nxt;
		end
	end

	// mode at launch, restored when the low-power step halts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			init_mode_r <= seq_pkg::MODE_STANDBY;
		else if (launch_go && !halt_r)
			init_mode_r <= chip_mode;
	end

	// restart pulse lines up with the one cycle spent in the relaunch state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rx_restart <= 1'b0;
		else
			rx_restart <= (state_nxt == seq_pkg::rx_relaunch_state);
	end

	assign mode_req   = mode_r;
	assign seq_active = (state_r != seq_pkg::seq_halted_state);

endmodule : radio_mode_sequencer

// ==== bench/seq_checker.sv ====
// port checker for radio_mode_sequencer, bound into every instance.
// assumes hreadyout stays high, so a taken address phase is followed by one data cycle.
`timescale 1ns/1ns
module seq_checker (
	input wire logic        hclk,                    // clock
	input wire logic        hresetn,                 // reset, low
	input wire logic        hsel,                    // select
	input wire logic [31:0] haddr,                   // address
	input wire logic [1:0]  htrans,                  // transfer
	input wire logic        hwrite,                  // write
	input wire logic [31:0] hwdata,                  // wdata
	input wire logic        hready,                  // ready
	input wire logic [2:0]  chip_mode,               // radio mode
	input wire logic        strength_deadline_event, // timeout a
	input wire logic        preamble_deadline_event, // timeout b
	input wire logic        sync_deadline_event,     // timeout c
	input wire logic [2:0]  mode_req,                // mode out
	input wire logic        seq_active,              // running
	input wire logic        rx_restart,              // restart
	input wire logic        first_timer_event,       // t1
	input wire logic        second_timer_event,      // t2
	input wire logic        rx_deadline_event        // timeout
);
//////////////////////////////////////////////////
logic ctrl_wr_r;
always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn)
		ctrl_wr_r <= 1'b0;
	else
		ctrl_wr_r <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == 8'h00);
end
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
sequence halt_wr;
	ctrl_wr_r && hwdata[1];
endsequence
sequence launch_wr;
	ctrl_wr_r && hwdata[0] && !hwdata[1];
endsequence
//////////////////////////////////////////////////
chk_timeout_or: assert property (rx_deadline_event == (strength_deadline_event | preamble_deadline_event | sync_deadline_event))
	else $error("timeout not the or of deadlines");
chk_halt_off: assert property (halt_wr |-> ##2 !seq_active)
	else $error("halt did not stop");
chk_halt_mode: assert property (halt_wr |-> ##2 $stable(mode_req))
	else $error("halt changed mode");
chk_launch_gate: assert property (launch_wr and (chip_mode > 3'h1 && !seq_active) |-> ##2 !seq_active)
	else $error("launch taken outside low power");
chk_restart_once: assert property (rx_restart |=> !rx_restart)
	else $error("restart longer than one cycle");
chk_restart_live: assert property (rx_restart |-> seq_active)
	else $error("restart while halted");
chk_restart_rx: assert property (rx_restart |-> mode_req == 3'h4)
	else $error("restart outside receive mode");
chk_t1_once: assert property (first_timer_event |=> !first_timer_event)
	else $error("timer1 pulse too long");
chk_timers_apart: assert property (first_timer_event |-> !second_timer_event)
	else $error("timers fired together");
endmodule : seq_checker
bind radio_mode_sequencer seq_checker chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.chip_mode, .strength_deadline_event, .preamble_deadline_event, .sync_deadline_event, .mode_req,
	.seq_active, .rx_restart, .first_timer_event, .second_timer_event, .rx_deadline_event);

// ==== bench/tb_radio_mode_sequencer.sv ====
// self-checking bench for radio_mode_sequencer through its AHB-Lite port and event pins.
// assumes short tick parameters: 4.1 ms tick shrunk to 40 cycles.
`timescale 1ns/1ns
module tb_radio_mode_sequencer;
//////////////////////////////////////////////////
logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, seq_active, rx_restart, t1, t2, rxd, lock;
logic [1:0]  htrans;
logic [2:0]  chip_mode, mode_req;
logic [10:0] ev;
logic [31:0] haddr, hwdata, hrdata, rd;
int          num_errors, n_compared, n;
logic [2:0]  texp [4] = '{3'h4, 3'h3, 3'h1, 3'h0};
// receive exit code, event pin fired, state expected after it
logic [2:0]  rxc [6] = '{3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6};
int          rxe [6] = '{1, 1, 2, 3, 4, 5};
logic [2:0]  rxs [6] = '{3'h1, 3'h3, 3'h5, 3'h0, 3'h0, 3'h0};
assign hready = hreadyout;
radio_mode_sequencer #(.RES2_CYC(40), .RES3_CYC(80)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chip_mode(chip_mode), .tx_done_event(ev[0]),
	.rx_payload_event(ev[1]), .check_pass_event(ev[2]), .strength_event(ev[3]), .sync_match_event(ev[4]),
	.preamble_found_event(ev[5]), .fifo_level_event(ev[6]), .fifo_drained_event(ev[7]),
	.strength_deadline_event(ev[8]), .preamble_deadline_event(ev[9]), .sync_deadline_event(ev[10]),
	.synth_locked(lock), .mode_req(mode_req), .seq_active(seq_active), .rx_restart(rx_restart),
	.first_timer_event(t1), .second_timer_event(t2), .rx_deadline_event(rxd));
initial begin
	hclk = 1'b0;
	forever #25 hclk = ~hclk;
end
//////////////////////////////////////////////////
task end_sim;
	$display("errors %0d compared %0d", num_errors, n_compared);
	if (num_errors == 0 && n_compared > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask : end_sim
task chk(input logic [31:0] s, input logic [31:0] e);
	n_compared++;
	if (s !== e) begin
		num_errors++;
		$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
	end
endtask : chk
// bounded wait at the sampling edge; a hang ends the run
task hold;
	int i;
	i = 0;
	do begin
		@(posedge hclk);
		i++;
	end while (hready !== 1'b1 && i < 20);
	if (i >= 20) begin
		num_errors++;
		end_sim();
	end
endtask : hold
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	@(posedge hclk);
	hsel <= 1'b1;
	haddr <= {24'h000000, a};
	htrans <= 2'h2;
	hwrite <= w;
	hold();
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= d;
	hold();
	rd = hrdata;
endtask : bus
task fire(input int k);
	@(posedge hclk);
	ev[k] <= 1'b1;
	@(negedge hclk);
	chk(rxd, |ev[10:8]);
	@(posedge hclk);
	ev <= 11'h000;
endtask : fire
task st(input logic [2:0] e);
	bus(1'b0, 8'h0C, 32'h00000000);
	chk(rd[2:0], e);
endtask : st
// counts falling edges until the chosen timer pulse is seen
task wpulse(input logic sel2, output int c);
	c = 0;
	do begin
		@(negedge hclk);
		c++;
	end while ((sel2 ? t2 : t1) !== 1'b1 && c < 3000);
	if (c >= 3000) begin
		num_errors++;
		end_sim();
	end
endtask : wpulse
// b = {tx exit, idle exit, low-power step, idle choice}
function automatic logic [31:0] cf(input logic [1:0] lx, input logic [2:0] rx, input logic [1:0] tx_o,
	input logic [2:0] gx, input logic [3:0] b);
	return {18'h00000, gx, tx_o, rx, b[3], b[2], b[1], lx, b[0]};
endfunction : cf
task relaunch(input logic [31:0] c);
	bus(1'b1, 8'h04, c);
	bus(1'b1, 8'h00, 32'h00000002);
	bus(1'b1, 8'h00, 32'h00000001);
endtask : relaunch
//////////////////////////////////////////////////
initial begin
	{hresetn, hsel, haddr, htrans, hwrite, hwdata, chip_mode, ev, lock, num_errors, n_compared} = '0;
	repeat (2) @(posedge hclk);
	chk(mode_req, seq_pkg::MODE_STANDBY);
	chk(seq_active, 1'b0);
	chk({hresp, hreadyout}, 32'h1);
	hresetn <= 1'b1;
	bus(1'b0, 8'h04, 32'h0);
	chk(rd, 32'h0);
	bus(1'b0, 8'h08, 32'h0);
	chk(rd, 32'h0);
	bus(1'b0, 8'h10, 32'h0);
	chk(rd, 32'h0);
	relaunch(cf(2'h1, 3'h1, 2'h0, 3'h0, 4'h0));
	st(3'h4);
	chk(mode_req, seq_pkg::MODE_RX);
	fire(1);
	st(3'h0);
	chip_mode <= 3'h3;
	bus(1'b1, 8'h00, 32'h00000001);
	st(3'h0);
	chip_mode <= 3'h0;
	for (int k = 0; k < 4; k++) begin
		relaunch(cf(2'h1, 3'h1, 2'(k), 3'h0, 4'h2));
		fire(8 + k % 3);
		st(texp[k]);
	end
	for (int k = 0; k < 6; k++) begin
		relaunch(cf(2'h1, rxc[k], 2'h1, 3'h1, 4'h2));
		fire(rxe[k]);
		st(rxs[k]);
	end
	relaunch(cf(2'h1, 3'h1, 2'h0, 3'h1, 4'h2));
	fire(1);
	st(3'h5);
	fire(7);
	st(3'h3);
	// synthesiser held unlocked so the wait state is visible
	relaunch(cf(2'h1, 3'h1, 2'h0, 3'h3, 4'h2));
	fire(1);
	st(3'h7);
	chk(mode_req, seq_pkg::MODE_SYNTH);
	lock <= 1'b1;
	st(3'h4);
	chip_mode <= 3'h1;
	relaunch(cf(2'h1, 3'h2, 2'h0, 3'h0, 4'h0));
	fire(1);
	st(3'h0);
	chk(mode_req, seq_pkg::MODE_STANDBY);
	chip_mode <= 3'h0;
	for (int j = 0; j < 2; j++) begin
		relaunch(cf(2'h0, 3'h0, 2'h0, 3'h0, {3'h1, 1'(j)}));
		fire(0);
		fire(1);
		st(3'h1);
		chk(mode_req, {2'h0, ~1'(j)});
	end
	relaunch(cf(2'h3, 3'h0, 2'h0, 3'h0, 4'h8));
	st(3'h2);
	fire(0);
	st(3'h2);
	fire(6);
	st(3'h3);
	fire(0);
	st(3'h4);
	bus(1'b1, 8'h00, 32'h00000003);
	st(3'h0);
	bus(1'b1, 8'h08, 32'h0003020A);
	relaunch(cf(2'h0, 3'h0, 2'h0, 3'h0, 4'h2));
	wpulse(1'b0, n);
	wpulse(1'b1, n);
	chk(n, 120);
	wpulse(1'b0, n);
	chk(n, 80);
	st(3'h3);
	bus(1'b1, 8'h00, 32'h00000002);
	wpulse(1'b1, n);
	wpulse(1'b0, n);
	chk(n, 80);
	relaunch(cf(2'h1, 3'h0, 2'h0, 3'h0, 4'h2));
	wpulse(1'b1, n);
	st(3'h1);
	end_sim();
end
endmodule : tb_radio_mode_sequencer
